//--- rtl/regb_ctl_consts.svh
// Purpose: constants for the register B capture/compare control
// Assumes: io control byte layout with the B field in bits 7..4
// Notes:   bit positions index the whole io control byte
`ifndef REGB_CTL_CONSTS_SVH
`define REGB_CTL_CONSTS_SVH

`define REGB_MODE_TOP_BIT        7
`define REGB_LEVEL_OR_SOURCE_BIT 6
`define REGB_ACTION_HIGH_BIT     5
`define REGB_ACTION_LOW_BIT      4
`define REGB_COUNT_WIDTH         16
`define REGB_RESET_VALUE         16'hFFFF
`define REGB_PIN_RESET_LEVEL     1'b0

`endif

//--- rtl/regb_ctl_pkg.sv
// Purpose: types shared by the register B control files
// Assumes: constants header supplies widths
// Notes:   none
`include "regb_ctl_consts.svh"

package regb_ctl_pkg;

  typedef logic [`REGB_COUNT_WIDTH-1:0] count_type;

  typedef enum logic [1:0] {
    act_none,
    act_low,
    act_high,
    act_toggle
  } cmp_action_type;

  typedef enum logic [1:0] {
    src_off,
    src_pin,
    src_ch0_event
  } cap_source_type;

endpackage

//--- rtl/pin_edge_sense.sv
// Purpose: synchronise one timer pin and report its edges
// Assumes: pin is asynchronous to clk; reset held three clocks flushes the chain
// Notes:   edges are seen two to three cycles after the pin moves
`timescale 1ns/1ns

module pin_edge_sense (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;
  logic last_r;
  logic last_nxt;

  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  // the chain keeps sampling in reset, so the delayed copy matches the pin
  // at release and a pin idling high shows no false rising edge
  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
    last_r <= last_nxt;
  end

  // only the second flop and its delayed copy feed the edge terms;
  // edges are held off while reset is high
  assign rise = ~sys_rst & sync_r & ~last_r;
  assign fall = ~sys_rst & ~sync_r & last_r;

endmodule

//--- rtl/timer_reg_b_capture_compare_ctl.sv
// Purpose: general register B compare/capture control for channels 1 and 2
// Assumes: counters and the channel 0 register C event come from the same clock;
//          cpu write strobes mark the second state of a register write cycle
// Notes:   pins are sampled through two flops before edge detection
// Operation
// - bits 7..4 configure B; bit7=0 compare
// - bit6 initial level; 00 disables output
// - action 10 drives pin high on match
// - action 11 toggles pin on match
// - channel 1 bit7=1 selects input capture
// - channel 1 bit6=0 captures from B pin
// - pin edge: 00 rise, 01 fall, 1x both
// - channel 1 bits 7,6 set: ch0 C events
// - channel 2 capture always from B pin
// - capture during write second state discards write
`timescale 1ns/1ns
`include "regb_ctl_consts.svh"

module timer_reg_b_capture_compare_ctl (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             ch1_io_ctl,
  input  wire logic [7:0]             ch2_io_ctl,
  input  wire regb_ctl_pkg::count_type ch1_count,
  input  wire regb_ctl_pkg::count_type ch2_count,
  input  wire logic                   ch1_count_tick,
  input  wire logic                   ch2_count_tick,
  input  wire logic                   ch0_regc_event,
  input  wire logic                   ch1_wr_t2,
  input  wire logic                   ch2_wr_t2,
  input  wire regb_ctl_pkg::count_type wr_data,
  input  wire logic                   ch1_b_io_pin_in,
  input  wire logic                   ch2_b_io_pin_in,
  output logic                        ch1_b_io_pin_out,
  output logic                        ch1_b_io_pin_oe,
  output logic                        ch2_b_io_pin_out,
  output logic                        ch2_b_io_pin_oe,
  output regb_ctl_pkg::count_type     ch1_general_reg_b,
  output regb_ctl_pkg::count_type     ch2_general_reg_b,
  output logic                        ch1_match_pulse,
  output logic                        ch2_match_pulse,
  output logic                        ch1_capture_pulse,
  output logic                        ch2_capture_pulse,
  output logic                        ch1_write_lost,
  output logic                        ch2_write_lost
);

  import regb_ctl_pkg::*;

  // index 0 is channel 1, index 1 is channel 2
  logic [7:0]     io_ctl    [2];
  count_type      count     [2];
  logic           tick      [2];
  logic           wr_t2     [2];
  logic           pin_rise  [2];
  logic           pin_fall  [2];

  count_type      regb_r    [2];
  count_type      regb_nxt  [2];
  logic           pin_r     [2];
  logic           pin_nxt   [2];
  logic           oe_r      [2];
  logic           oe_nxt    [2];
  logic           match_r   [2];
  logic           match_nxt [2];
  logic           cap_r     [2];
  logic           cap_nxt   [2];
  logic           lost_r    [2];
  logic           lost_nxt  [2];
  logic [3:0]     field_r   [2];
  logic [3:0]     field_nxt [2];

  cmp_action_type action    [2];
  cap_source_type source    [2];
  logic           capture   [2];
  logic           compare   [2];

  assign io_ctl[0] = ch1_io_ctl;
  assign io_ctl[1] = ch2_io_ctl;
  assign count[0]  = ch1_count;
  assign count[1]  = ch2_count;
  assign tick[0]   = ch1_count_tick;
  assign tick[1]   = ch2_count_tick;
  assign wr_t2[0]  = ch1_wr_t2;
  assign wr_t2[1]  = ch2_wr_t2;

  // pin edges lag the pin by two to three clocks
  pin_edge_sense u_ch1_sense (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (ch1_b_io_pin_in),
    .rise    (pin_rise[0]),
    .fall    (pin_fall[0])
  );

  pin_edge_sense u_ch2_sense (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (ch2_b_io_pin_in),
    .rise    (pin_rise[1]),
    .fall    (pin_fall[1])
  );

  // ch0 register C events share this clock, so they need no synchroniser
  // decode the B field into a compare action and a capture source
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      action[i] = act_none;
      source[i] = src_off;
      if (!io_ctl[i][`REGB_MODE_TOP_BIT]) begin
        case ({io_ctl[i][`REGB_ACTION_HIGH_BIT], io_ctl[i][`REGB_ACTION_LOW_BIT]})
          2'h0:    action[i] = act_none;
          2'h1:    action[i] = act_low;
          2'h2:    action[i] = act_high;
          default: action[i] = act_toggle;
        endcase
      end else if (i == 0 && io_ctl[i][`REGB_LEVEL_OR_SOURCE_BIT]) begin
        source[i] = src_ch0_event;
      end else begin
        // channel 2 ignores bit 6 here
        source[i] = src_pin;
      end
    end
  end

  // capture trigger per selected source and edge
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      capture[i] = 1'b0;
      case (source[i])
        src_pin: begin
          if (io_ctl[i][`REGB_ACTION_HIGH_BIT]) begin
            capture[i] = pin_rise[i] | pin_fall[i];
          end else if (io_ctl[i][`REGB_ACTION_LOW_BIT]) begin
            capture[i] = pin_fall[i];
          end else begin
            capture[i] = pin_rise[i];
          end
        end
        src_ch0_event: capture[i] = ch0_regc_event;
        default:       capture[i] = 1'b0;
      endcase
      // the tick qualifier keeps a stalled counter from matching every clock
      compare[i] = !io_ctl[i][`REGB_MODE_TOP_BIT] && tick[i] && (count[i] == regb_r[i]);
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      regb_nxt[i]  = regb_r[i];
      pin_nxt[i]   = pin_r[i];
      oe_nxt[i]    = 1'b0;
      lost_nxt[i]  = 1'b0;
      field_nxt[i] = io_ctl[i][7:4];
      match_nxt[i] = compare[i];
      cap_nxt[i]   = capture[i];
      // a capture in the write's second state wins and the write is dropped
      if (capture[i]) begin
        regb_nxt[i] = count[i];
        lost_nxt[i] = wr_t2[i];
      end else if (wr_t2[i]) begin
        regb_nxt[i] = wr_data;
      end
      if (!io_ctl[i][`REGB_MODE_TOP_BIT]) begin
        // a change of the field reloads the initial level before any match
        if (io_ctl[i][7:4] != field_r[i]) begin
          pin_nxt[i] = io_ctl[i][`REGB_LEVEL_OR_SOURCE_BIT];
        end else if (compare[i]) begin
          case (action[i])
            act_low:    pin_nxt[i] = 1'b0;
            act_high:   pin_nxt[i] = 1'b1;
            act_toggle: pin_nxt[i] = ~pin_r[i];
            default:    pin_nxt[i] = pin_r[i];
          endcase
        end
        // a disabled output keeps its level registered, ready for the next enable
        oe_nxt[i] = (action[i] != act_none);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 2; i++) begin
        regb_r[i]  <= `REGB_RESET_VALUE;
        pin_r[i]   <= `REGB_PIN_RESET_LEVEL;
        oe_r[i]    <= 1'b0;
        match_r[i] <= 1'b0;
        cap_r[i]   <= 1'b0;
        lost_r[i]  <= 1'b0;
        // zero copy: a nonzero field with bit7=0 loads its initial level on release
        field_r[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        regb_r[i]  <= regb_nxt[i];
        pin_r[i]   <= pin_nxt[i];
        oe_r[i]    <= oe_nxt[i];
        match_r[i] <= match_nxt[i];
        cap_r[i]   <= cap_nxt[i];
        lost_r[i]  <= lost_nxt[i];
        field_r[i] <= field_nxt[i];
      end
    end
  end

  assign ch1_b_io_pin_out  = pin_r[0];
  assign ch1_b_io_pin_oe   = oe_r[0];
  assign ch2_b_io_pin_out  = pin_r[1];
  assign ch2_b_io_pin_oe   = oe_r[1];
  assign ch1_general_reg_b = regb_r[0];
  assign ch2_general_reg_b = regb_r[1];
  assign ch1_match_pulse   = match_r[0];
  assign ch2_match_pulse   = match_r[1];
  assign ch1_capture_pulse = cap_r[0];
  assign ch2_capture_pulse = cap_r[1];
  assign ch1_write_lost    = lost_r[0];
  assign ch2_write_lost    = lost_r[1];

endmodule

//--- test/timer_reg_b_capture_compare_ctl_chk.sv
// Purpose: port assertions for the register B control
// Assumes: one clock, synchronous reset
// Notes:   channel 1 only, channel 2 is the same logic
`timescale 1ns/1ns
module timer_reg_b_capture_compare_ctl_chk (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic [7:0]              ch1_io_ctl,
  input wire regb_ctl_pkg::count_type ch1_count,
  input wire logic                    ch1_count_tick,
  input wire logic                    ch1_wr_t2,
  input wire regb_ctl_pkg::count_type wr_data,
  input wire logic                    ch1_b_io_pin_out,
  input wire logic                    ch1_b_io_pin_oe,
  input wire regb_ctl_pkg::count_type ch1_general_reg_b,
  input wire logic                    ch1_match_pulse,
  input wire logic                    ch1_write_lost
);
  import regb_ctl_pkg::*;
  logic [7:0] ctl_r;
  logic [1:0] act;
  logic       rst_r;
  logic       hit;
  logic       hs;
  always_ff @(posedge clk) begin
    ctl_r <= ch1_io_ctl;
    rst_r <= sys_rst;
  end
  assign act = ch1_io_ctl[5:4];
  assign hit = !ch1_io_ctl[7] && ch1_count_tick && ch1_count == ch1_general_reg_b;
  // a field change outranks a match, so action checks want a settled field
  assign hs = hit && ch1_io_ctl == ctl_r && !rst_r;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_oe_drive: assert property (
    !ch1_io_ctl[7] && act != 2'h0 |=> ch1_b_io_pin_oe) else $error("oe not set");
  chk_match_pulse: assert property (
    hit |=> ch1_match_pulse) else $error("no match pulse");
  chk_match_high: assert property (
    hs && act == 2'h2 |=> ch1_b_io_pin_out) else $error("pin not high");
  chk_match_low: assert property (
    hs && act == 2'h1 |=> !ch1_b_io_pin_out) else $error("pin not low");
  chk_match_toggle: assert property (
    hs && act == 2'h3 |=> ch1_b_io_pin_out != $past(ch1_b_io_pin_out)) else $error("no toggle");
  chk_field_level: assert property (
    !ch1_io_ctl[7] && ch1_io_ctl[7:4] != ctl_r[7:4] && !rst_r |=> ch1_b_io_pin_out == ctl_r[6])
    else $error("initial level wrong");
  chk_write_take: assert property (
    ch1_wr_t2 |=> ch1_write_lost || ch1_general_reg_b == $past(wr_data)) else $error("write lost");
  chk_lost_capture: assert property (
    ch1_write_lost |-> ch1_general_reg_b == $past(ch1_count)) else $error("capture missing");
endmodule

bind timer_reg_b_capture_compare_ctl timer_reg_b_capture_compare_ctl_chk chk_i (
  .clk, .sys_rst, .ch1_io_ctl, .ch1_count, .ch1_count_tick, .ch1_wr_t2, .wr_data,
  .ch1_b_io_pin_out, .ch1_b_io_pin_oe, .ch1_general_reg_b, .ch1_match_pulse, .ch1_write_lost
);

//--- test/pin_drv_model.sv
// Purpose: far side driver of the two B pins
// Assumes: plain levels, no pull
// Notes:   slow adds a cycle so capture latency varies
`timescale 1ns/1ns
module pin_drv_model (
  input  wire logic       clk,
  input  wire logic [1:0] want,
  input  wire logic       slow,
  output logic      [1:0] pin
);
  logic [1:0] want_r;
  always_ff @(posedge clk) want_r <= want;
  assign pin = slow ? want_r : want;
endmodule

//--- test/timer_reg_b_capture_compare_ctl_tb.sv
// Purpose: random and corner tests of the register B control
// Assumes: pins come through the partner model
// Notes:   both channels get the same compare traffic
`timescale 1ns/1ns
`include "regb_ctl_consts.svh"
module timer_reg_b_capture_compare_ctl_tb;
  import regb_ctl_pkg::*;
  logic       clk = 1'b0, sys_rst = 1'b1, ev = 1'b0, slow = 1'b0;
  logic [7:0] c1 = 8'h00, c2 = 8'h00;
  logic [1:0] wt = 2'h0, tk = 2'h0, want = 2'h0;
  logic [1:0] pin, po, oe, mp, cap, lost;
  count_type  cnt1 = 16'h0000, cnt2 = 16'h0000, wd = 16'h0000;
  count_type  r1, r2, d, e1, e2;
  int         seed = 32'h33ED, mismatches = 0, num_checks = 0;
  always #20 clk = ~clk;
  pin_drv_model pin_drv_model_i (.clk(clk), .want(want), .slow(slow), .pin(pin));
  timer_reg_b_capture_compare_ctl timer_reg_b_capture_compare_ctl_i (
    .clk(clk), .sys_rst(sys_rst), .ch1_io_ctl(c1), .ch2_io_ctl(c2),
    .ch1_count(cnt1), .ch2_count(cnt2), .ch1_count_tick(tk[1]), .ch2_count_tick(tk[0]),
    .ch0_regc_event(ev), .ch1_wr_t2(wt[1]), .ch2_wr_t2(wt[0]), .wr_data(wd),
    .ch1_b_io_pin_in(pin[1]), .ch2_b_io_pin_in(pin[0]), .ch1_b_io_pin_out(po[1]),
    .ch1_b_io_pin_oe(oe[1]), .ch2_b_io_pin_out(po[0]), .ch2_b_io_pin_oe(oe[0]),
    .ch1_general_reg_b(r1), .ch2_general_reg_b(r2), .ch1_match_pulse(mp[1]),
    .ch2_match_pulse(mp[0]), .ch1_capture_pulse(cap[1]), .ch2_capture_pulse(cap[0]),
    .ch1_write_lost(lost[1]), .ch2_write_lost(lost[0]));
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic exp_pin(input logic [1:0] a, input logic b6);
    return a == 2'h0 ? b6 : a == 2'h1 ? 1'b0 : a == 2'h2 ? 1'b1 : !b6;
  endfunction
  // the sync delay is not fixed, so pulses are gathered over a window
  task automatic edge_try(input logic lv, input logic [1:0] ex);
    logic [1:0] got;
    got = 2'h0;
    @(posedge clk);
    d = 16'($random(seed));
    want <= {2{lv}};
    slow <= d[0];
    {cnt1, cnt2} <= {d, d};
    repeat (8) begin
      @(posedge clk);
      #1 got = got | cap;
    end
    if (ex[1]) e1 = d;
    if (ex[0]) e2 = d;
    check("capture", 16'(got), 16'(ex));
    check("cap_b1", r1, e1);
    check("cap_b2", r2, e2);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      @(posedge clk);
      {c1, c2} <= {2{1'b0, 3'(a), 4'h0}};
      d = 16'($random(seed));
      @(posedge clk);
      wt <= 2'h3;
      wd <= d;
      @(posedge clk);
      wt <= 2'h0;
      {cnt1, cnt2} <= {d, d};
      tk <= 2'h3;
      #1 check("pin_init", 16'(po), 16'({2{a[2]}}));
      check("oe", 16'(oe), 16'({2{a[1:0] != 2'h0}}));
      check("wr_b1", r1, d);
      check("wr_b2", r2, d);
      @(posedge clk);
      tk <= 2'h0;
      #1 check("match", 16'(mp), 16'h0003);
      check("pin_match", 16'(po), 16'({2{exp_pin(2'(a), a[2])}}));
      e1 = d;
      e2 = d;
    end
    $display("compare test done");
    for (int e = 0; e < 4; e++) begin
      @(posedge clk);
      c1 <= 8'h80 | 8'(e << 4);
      c2 <= 8'hC0 | 8'(e << 4);
      edge_try(1'b1, {2{e != 1}});
      edge_try(1'b0, {2{e != 0}});
    end
    $display("capture test done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      d = 16'($random(seed));
      c1 <= {2'h3, d[5:0]};
      cnt1 <= d;
      @(posedge clk);
      ev <= 1'b1;
      wt <= {k[0], 1'b0};
      wd <= ~d;
      @(posedge clk);
      ev <= 1'b0;
      wt <= 2'h0;
      #1 check("ev_cap", r1, d);
      check("lost", 16'(lost), 16'({k[0], 1'b0}));
    end
    $display("event test done");
    @(posedge clk);
    sys_rst <= 1'b1;
    {c1, c2} <= {8'h40, 8'h70};
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1 check("rst_b1", r1, `REGB_RESET_VALUE);
    check("rst_b2", r2, `REGB_RESET_VALUE);
    check("rst_oe", 16'(oe), 16'h0000);
    check("rst_pin", 16'(po), 16'({2{`REGB_PIN_RESET_LEVEL}}));
    @(posedge clk);
    #1 check("rst_level", 16'(po), 16'h0003);
    check("rst_oe_on", 16'(oe), 16'h0001);
    $display("reset test done");
    report_and_stop;
  end
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
endmodule
